// *** icsr_top.sv ***
// Control and status block of a two-wire bus controller
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Reading start clear clears start event
// - Reading general_address_event clear clears general_address_event event
// - Enable resets zero; disabled flushes both queues
// - Event status survives disable until cleared
// - Disable while sending: finish, drop TX
// - Disable while receiving: stop, no ack
// - Enable change applies two cycles later
// - Status bit 6 shows slave busy
// - Status bit 5 shows master busy
// - Status bit 4 shows RX full
// - RX not empty bit tracks RX count
// - Status bit 2 TX empty, no interrupt
// - Status bit 1 TX has free space
// - TX level reports TX count
// - RX level reports RX count
// - Read command while slave sends sets abort
// - Abort clear read clears abort, releases TX
module icsr_top
    import icsr_pkg::*;
#(
    parameter int TX_DEPTH = 32, // TX queue entries
    parameter int RX_DEPTH = 32  // RX queue entries
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Bus engine side
    input  wire icsr_eng_t   eng,
    input  wire logic        tx_pop,
    input  wire logic        rx_push,
    input  wire logic [7:0]  rx_data,
    output logic      [8:0]  tx_word,
    output logic             tx_valid,
    output logic             core_enable,
    output logic             stop_request,
    output logic             rx_nack,
    output logic      [15:0] data_line_hold,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    localparam int TXA = $clog2(TX_DEPTH);
    localparam int RXA = $clog2(RX_DEPTH);
    initial begin
        if (TX_DEPTH < 2 || TX_DEPTH > 32 || (1 << TXA) != TX_DEPTH ||
            RX_DEPTH < 2 || RX_DEPTH > 32 || (1 << RXA) != RX_DEPTH) begin
            $error("icsr_top: depths must be powers of two, 2 to 32");
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic hit_abort_clr = (addr == OFF_ABORT_CLR);
    wire logic hit_start_clr = (addr == OFF_START_CLR);
    wire logic hit_gen_clr   = (addr == OFF_GENCALL_CLR);
    wire logic hit_enable    = (addr == OFF_ENABLE);
    wire logic hit_status    = (addr == OFF_STATUS);
    wire logic hit_txlvl     = (addr == OFF_TX_LEVEL);
    wire logic hit_rxlvl     = (addr == OFF_RX_LEVEL);
    wire logic hit_hold      = (addr == OFF_HOLD);
    wire logic hit_cause     = (addr == OFF_ABORT_CAUSE);
    wire logic hit_evt_st    = (addr == OFF_EVT_STATUS);
    wire logic hit_evt_clr   = (addr == OFF_EVT_CLEAR);
    wire logic hit_evt_en    = (addr == OFF_EVT_ENABLE);
    wire logic hit_data      = (addr == OFF_DATA_CMD);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic        ctrl_en;    // Software enable bit
    logic        en_d1;      // First delay stage
    logic        en_eff;     // Enable as seen by the logic
    logic [15:0] hold_time;  // Data line hold setting
    logic [15:0] evt_en;     // Event interrupt enables
    logic [15:0] evt_st;     // Sticky raw events
    logic        abrt_slvrd; // Abort cause bit
    logic        tx_blocked; // TX held flushed after abort

    // Software writes; reserved bits are not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_en   <= 1'b0;
            hold_time <= RST_HOLD;
            evt_en    <= 16'h0000;
        end else if (wr) begin
            if (hit_enable) begin
                ctrl_en <= wdata[0];
            end else if (hit_hold) begin
                hold_time <= wdata[15:0];
            end else if (hit_evt_en) begin
                evt_en <= wdata[15:0] & EVT_MASK;
            end
        end
    end

    // Two-stage delay before an enable change takes effect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_d1  <= 1'b0;
            en_eff <= 1'b0;
        end else begin
            en_d1  <= ctrl_en;
            en_eff <= en_d1;
        end
    end

    assign core_enable    = en_eff;
    // Engine finishes its current transfer, then stops
    assign stop_request   = !en_eff;
    // Byte in progress when disabled is not acknowledged
    assign rx_nack        = !en_eff;
    assign data_line_hold = hold_time;

    // ------------------------------------------------------------------
    // Queue control
    // ------------------------------------------------------------------
    logic [5:0]     tx_cnt;   // Valid TX entries
    logic [5:0]     rx_cnt;   // Valid RX entries
    logic [TXA-1:0] tx_wp;    // TX write index
    logic [TXA-1:0] tx_rp;    // TX read index
    logic [RXA-1:0] rx_wp;    // RX write index
    logic [RXA-1:0] rx_rp;    // RX read index
    logic [8:0]     tx_mem [TX_DEPTH]; // TX storage
    logic [7:0]     rx_mem [RX_DEPTH]; // RX storage

    wire logic tx_full  = (tx_cnt == 6'(TX_DEPTH));
    wire logic tx_empty = (tx_cnt == 6'h00);
    wire logic rx_full  = (rx_cnt == 6'(RX_DEPTH));
    wire logic rx_empty = (rx_cnt == 6'h00);
    // Read command while the slave is asked for data is an abort
    wire logic slvrd_err = wr && hit_data && eng.slave_rd_req &&
                           wdata[BIT_CMD_READ];
    wire logic tx_flush  = !en_eff || tx_blocked || slvrd_err;
    wire logic rx_flush  = !en_eff;
    wire logic tx_push   = wr && hit_data && !tx_full && !slvrd_err;
    wire logic tx_take   = tx_pop && !tx_empty;
    wire logic rx_put    = rx_push && !rx_full;
    wire logic rx_take   = rd && hit_data && !rx_empty;
    wire logic abort_clr = rd && hit_abort_clr;

    // TX indices and count, flushed while disabled or aborted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= 6'h00;
        end else if (tx_flush) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= 6'h00;
        end else begin
            tx_wp  <= tx_wp + TXA'(tx_push);
            tx_rp  <= tx_rp + TXA'(tx_take);
            tx_cnt <= tx_cnt + 6'(tx_push) - 6'(tx_take);
        end
    end

    // RX indices and count, flushed while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wp  <= '0;
            rx_rp  <= '0;
            rx_cnt <= 6'h00;
        end else if (rx_flush) begin
            rx_wp  <= '0;
            rx_rp  <= '0;
            rx_cnt <= 6'h00;
        end else begin
            rx_wp  <= rx_wp + RXA'(rx_put);
            rx_rp  <= rx_rp + RXA'(rx_take);
            rx_cnt <= rx_cnt + 6'(rx_put) - 6'(rx_take);
        end
    end

    // Queue storage, one flip-flop word per entry
    always_ff @(posedge clk) begin
        if (tx_push && !tx_flush) begin
            tx_mem[tx_wp] <= wdata[8:0];
        end
        if (rx_put && !rx_flush) begin
            rx_mem[rx_wp] <= rx_data;
        end
    end

    assign tx_word  = tx_mem[tx_rp];
    assign tx_valid = !tx_empty;

    // ------------------------------------------------------------------
    // Events and abort cause
    // ------------------------------------------------------------------
    // Setting wins over a clear in the same cycle; disable never clears
    wire logic [15:0] evt_set = (16'(eng.start_seen)   << BIT_EVT_START) |
                                (16'(eng.general_addr) << BIT_EVT_GENCALL) |
                                (16'(slvrd_err)        << BIT_EVT_ABORT);
    wire logic [15:0] evt_clr =
        ((wr && hit_evt_clr) ? wdata[15:0] : 16'h0000) |
        (16'(rd && hit_start_clr) << BIT_EVT_START)    |
        (16'(rd && hit_gen_clr)   << BIT_EVT_GENCALL)  |
        (16'(abort_clr)           << BIT_EVT_ABORT);
    wire logic [15:0] next_evt_st = ((evt_st & ~evt_clr) | evt_set) &
                                    EVT_MASK;
    wire logic [15:0] masked_event_status = evt_st & evt_en;

    // Sticky event register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_st <= 16'h0000;
        end else begin
            evt_st <= next_evt_st;
        end
    end

    // Abort cause and TX hold-off, released by the abort clear read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            abrt_slvrd <= 1'b0;
            tx_blocked <= 1'b0;
        end else if (slvrd_err) begin
            abrt_slvrd <= 1'b1;
            tx_blocked <= 1'b1;
        end else if (abort_clr) begin
            abrt_slvrd <= 1'b0;
            tx_blocked <= 1'b0;
        end
    end

    // Level interrupt from enabled events; TX empty never requests one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_evt_st & evt_en);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire logic [15:0] status_word =
        (16'(eng.slave_busy)  << BIT_ST_SLAVE)   |
        (16'(eng.master_busy) << BIT_ST_MASTER)  |
        (16'(rx_full)         << BIT_ST_RXFULL)  |
        (16'(!rx_empty)       << BIT_ST_RXNE)    |
        (16'(tx_empty)        << BIT_ST_TXEMPTY) |
        (16'(!tx_full)        << BIT_ST_TXSPACE) |
        (16'(eng.slave_busy || eng.master_busy) << BIT_ST_ACTIVE);

    wire logic [15:0] next_rdata =
        hit_start_clr ? 16'(evt_st[BIT_EVT_START])   :
        hit_gen_clr   ? 16'(evt_st[BIT_EVT_GENCALL]) :
        hit_abort_clr ? 16'(evt_st[BIT_EVT_ABORT])   :
        hit_enable    ? 16'(ctrl_en)                 :
        hit_status    ? status_word                  :
        hit_txlvl     ? {10'h000, tx_cnt}            :
        hit_rxlvl     ? {10'h000, rx_cnt}            :
        hit_hold      ? hold_time                    :
        hit_cause     ? 16'(abrt_slvrd) << BIT_ABRT_SLVRD :
        hit_evt_st    ? evt_st                       :
        hit_evt_en    ? evt_en                       :
        hit_data      ? {8'h00, rx_mem[rx_rp]}       :
                        16'h0000;

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= {16'h0000, next_rdata};
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_start_clr;
        rd && hit_start_clr && !eng.start_seen;
    endsequence

    property p_start_clr;
        @(posedge clk) disable iff (!rst_n)
        s_start_clr |=> !evt_st[BIT_EVT_START];
    endproperty
    a_start_clr: assert property (p_start_clr) else
        $error("start event not cleared by read");

    property p_gen_clr;
        @(posedge clk) disable iff (!rst_n)
        rd && hit_gen_clr && !eng.general_addr |=>
            !evt_st[BIT_EVT_GENCALL];
    endproperty
    a_gen_clr: assert property (p_gen_clr) else
        $error("general call event not cleared by read");

    property p_en_delay;
        @(posedge clk) disable iff (!rst_n)
        $rose(ctrl_en) |-> !en_eff ##1 !en_eff ##1 en_eff;
    endproperty
    a_en_delay: assert property (p_en_delay) else
        $error("enable did not apply two cycles later");

    property p_flush;
        @(posedge clk) disable iff (!rst_n)
        !en_eff |=> tx_cnt == 6'h00 && rx_cnt == 6'h00;
    endproperty
    a_flush: assert property (p_flush) else
        $error("queues not empty while disabled");

    property p_busy_bits;
        @(posedge clk) disable iff (!rst_n)
        rd && hit_status |=>
            rdata[BIT_ST_SLAVE]  == $past(eng.slave_busy) &&
            rdata[BIT_ST_MASTER] == $past(eng.master_busy);
    endproperty
    a_busy_bits: assert property (p_busy_bits) else
        $error("activity bits do not follow FSM state");

    property p_tx_flags;
        @(posedge clk) disable iff (!rst_n)
        rd && hit_status |=>
            rdata[BIT_ST_TXEMPTY] == ($past(tx_cnt) == 6'h00) &&
            rdata[BIT_ST_RXNE]    == ($past(rx_cnt) != 6'h00);
    endproperty
    a_tx_flags: assert property (p_tx_flags) else
        $error("queue flags disagree with counts");

    property p_level;
        @(posedge clk) disable iff (!rst_n)
        rd && hit_txlvl |=> rdata == {26'h0, $past(tx_cnt)};
    endproperty
    a_level: assert property (p_level) else
        $error("TX level read wrong");

    property p_rx_level;
        @(posedge clk) disable iff (!rst_n)
        rd && hit_rxlvl |=> rdata == {26'h0, $past(rx_cnt)};
    endproperty
    a_rx_level: assert property (p_rx_level) else
        $error("RX level read wrong");

    property p_abort_set;
        @(posedge clk) disable iff (!rst_n)
        slvrd_err |=> abrt_slvrd && evt_st[BIT_EVT_ABORT] &&
                      tx_cnt == 6'h00;
    endproperty
    a_abort_set: assert property (p_abort_set) else
        $error("slave read command abort not recorded");

    property p_abort_clr;
        @(posedge clk) disable iff (!rst_n)
        abort_clr && !slvrd_err |=> !abrt_slvrd && !tx_blocked &&
                                    !evt_st[BIT_EVT_ABORT];
    endproperty
    a_abort_clr: assert property (p_abort_clr) else
        $error("abort clear read did not release TX");

endmodule : icsr_top
`default_nettype wire

// *** icsr_pkg.sv ***
// Constants and types shared by the two-wire controller control/status block
package icsr_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] OFF_ABORT_CLR   = 32'h5000_1454; // Abort clear
    localparam logic [31:0] OFF_START_CLR   = 32'h5000_1464; // Start clear
    localparam logic [31:0] OFF_GENCALL_CLR = 32'h5000_1468; // General_address_event clr
    localparam logic [31:0] OFF_ENABLE      = 32'h5000_146c; // Enable
    localparam logic [31:0] OFF_STATUS      = 32'h5000_1470; // Status
    localparam logic [31:0] OFF_TX_LEVEL    = 32'h5000_1474; // TX level
    localparam logic [31:0] OFF_RX_LEVEL    = 32'h5000_1478; // RX level
    localparam logic [31:0] OFF_HOLD        = 32'h5000_147c; // Hold time
    localparam logic [31:0] OFF_ABORT_CAUSE = 32'h5000_1480; // Abort cause
    localparam logic [31:0] OFF_EVT_STATUS  = 32'h5000_1484; // Sticky events
    localparam logic [31:0] OFF_EVT_CLEAR   = 32'h5000_1488; // W1 clear
    localparam logic [31:0] OFF_EVT_ENABLE  = 32'h5000_148c; // Event enable
    localparam logic [31:0] OFF_DATA_CMD    = 32'h5000_1490; // Data/command

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_EVT_ABORT   = 6;  // Abort event
    localparam int BIT_EVT_START   = 10; // Start condition seen
    localparam int BIT_EVT_GENCALL = 11; // General call address seen
    localparam int BIT_ST_SLAVE    = 6;  // Slave FSM busy
    localparam int BIT_ST_MASTER   = 5;  // Master FSM busy
    localparam int BIT_ST_RXFULL   = 4;  // RX queue full
    localparam int BIT_ST_RXNE     = 3;  // RX queue not empty
    localparam int BIT_ST_TXEMPTY  = 2;  // TX queue empty
    localparam int BIT_ST_TXSPACE  = 1;  // TX queue has space
    localparam int BIT_ST_ACTIVE   = 0;  // Any FSM busy
    localparam int BIT_ABRT_SLVRD  = 15; // Read command while slave sends
    localparam int BIT_CMD_READ    = 8;  // Read command in data word

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_HOLD      = 16'h0001; // Hold time reset
    localparam logic [15:0] EVT_MASK      = 16'h0c40; // Implemented events
    localparam int          ENABLE_DELAY  = 2;        // Cycles to apply enable

    // Status from the bus engine
    typedef struct packed {
        logic master_busy;   // Master FSM not idle
        logic slave_busy;    // Slave FSM not idle
        logic start_seen;    // Pulse: start condition
        logic general_addr;  // Pulse: general call received
        logic slave_rd_req;  // Level: remote master wants data
    } icsr_eng_t;

endpackage : icsr_pkg

// *** icsr_eng_model.sv ***
// Behavioural model of the bus engine on the far side of the block
`timescale 1ns/1ns
`default_nettype none
module icsr_eng_model
    import icsr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Requests from the bench
    input  wire logic       want_push,
    input  wire logic       want_pop,
    input  wire logic       want_start,
    input  wire logic       want_gen,
    input  wire logic       mst_on,
    input  wire logic       slv_on,
    input  wire logic       rd_req,
    // Block side
    input  wire logic [8:0] tx_word,
    input  wire logic       tx_valid,
    input  wire logic       rx_nack,
    output icsr_eng_t       eng,
    output logic            tx_pop,
    output logic            rx_push,
    output logic      [7:0] rx_data,
    // Last word taken from the TX queue
    output logic      [8:0] popped
);
    // ------------------------------------------------------------------
    // Engine state
    // ------------------------------------------------------------------
    logic [7:0] next_byte; // Next byte to deliver

    // Events are one-cycle pulses; an idle data line shows the inverse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eng       <= '0;
            tx_pop    <= 1'b0;
            rx_push   <= 1'b0;
            rx_data   <= 8'h00;
            next_byte <= 8'ha0;
            popped    <= 9'h000;
        end else begin
            eng.master_busy  <= mst_on;
            eng.slave_busy   <= slv_on;
            eng.start_seen   <= want_start;
            eng.general_addr <= want_gen;
            eng.slave_rd_req <= rd_req;
            // Take a word only when one is offered
            tx_pop <= want_pop & tx_valid;
            // No new byte once the block refuses to acknowledge
            rx_push <= want_push & !rx_nack;
            if (want_push && !rx_nack) begin
                rx_data   <= next_byte;
                next_byte <= next_byte + 8'h01;
            end else begin
                rx_data <= ~rx_data;
            end
            // Keep what was popped for the bench
            if (tx_pop) begin
                popped <= tx_word;
            end
        end
    end
endmodule : icsr_eng_model
`default_nettype wire

// *** icsr_top_test.sv ***
// Self-checking testbench of the control and status block
`timescale 1ns/1ns
`default_nettype none
module icsr_top_test;
    import icsr_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk = 1'b0;      // 50 MHz clock
    logic        rst_n = 1'b0;    // Active-low reset
    logic [31:0] addr = '0;       // Register address
    logic [31:0] wdata = '0;      // Write data
    logic        wr = 1'b0;       // Write strobe
    logic        rd = 1'b0;       // Read strobe
    logic [31:0] rdata;           // Read data
    icsr_eng_t   eng;             // Engine status
    logic        tx_pop, rx_push; // Engine strobes
    logic [7:0]  rx_data;         // Received byte
    logic [8:0]  tx_word, popped; // TX head and last popped word
    logic        tx_valid, core_enable, stop_request, rx_nack, irq;
    logic [15:0] data_line_hold;  // Hold time output
    logic        w_push = 0, w_pop = 0, w_start = 0, w_gen = 0;
    logic        mst = 0, slv = 0, rdq = 0; // Engine levels
    int          fails = 0;       // Mismatches
    int          num_checks = 0;  // Comparisons
    int          cycles = 0;      // Timeout counter
    logic [31:0] v;               // Read result

    // Clock generator
    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Design and engine model
    // ------------------------------------------------------------------
    icsr_top #(.TX_DEPTH(4), .RX_DEPTH(4)) u_icsr_top (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .eng(eng), .tx_pop(tx_pop),
        .rx_push(rx_push), .rx_data(rx_data), .tx_word(tx_word),
        .tx_valid(tx_valid), .core_enable(core_enable),
        .stop_request(stop_request), .rx_nack(rx_nack),
        .data_line_hold(data_line_hold), .irq(irq));
    icsr_eng_model u_icsr_eng_model (
        .clk(clk), .rst_n(rst_n), .want_push(w_push), .want_pop(w_pop),
        .want_start(w_start), .want_gen(w_gen), .mst_on(mst),
        .slv_on(slv), .rd_req(rdq), .tx_word(tx_word),
        .tx_valid(tx_valid), .rx_nack(rx_nack), .eng(eng),
        .tx_pop(tx_pop), .rx_push(rx_push), .rx_data(rx_data),
        .popped(popped));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, reserved bits and the hold-time register
    task automatic t_reset;
        rd_reg(OFF_STATUS, v);      check(v, 32'h0000_0006);
        rd_reg(OFF_ENABLE, v);      check(v, 32'h0);
        rd_reg(OFF_TX_LEVEL, v);    check(v, 32'h0);
        rd_reg(OFF_RX_LEVEL, v);    check(v, 32'h0);
        rd_reg(OFF_ABORT_CAUSE, v); check(v, 32'h0);
        rd_reg(OFF_HOLD, v);        check(v, {16'h0000, RST_HOLD});
        rd_reg(32'h5000_14f0, v);   check(v, 32'h0);
        wr_reg(OFF_HOLD, 32'h1234_abcd);
        rd_reg(OFF_HOLD, v);        check(v, 32'h0000_abcd);
        check(data_line_hold, 32'h0000_abcd);
        check(core_enable, 32'h0);
    endtask : t_reset

    // Enable takes effect two cycles after the bit changes
    task automatic t_enable(input logic on);
        wr_reg(OFF_ENABLE, on ? 32'h0000_ffff : 32'h0);
        cyc(1); check(core_enable, !on);
        cyc(1); check(core_enable, on);
        check(stop_request, !on);
        rd_reg(OFF_ENABLE, v); check(v, on);
    endtask : t_enable

    // Sticky events, their clear reads and the interrupt
    task automatic t_events;
        wr_reg(OFF_EVT_ENABLE, {16'h0000, EVT_MASK});
        @(posedge clk) w_start <= 1'b1;
        @(posedge clk) w_start <= 1'b0;
        cyc(3); check(irq, 32'h1);
        rd_reg(OFF_EVT_STATUS, v); check(v, 32'h0000_0400);
        rd_reg(OFF_START_CLR, v);  check(v, 32'h0000_0001);
        rd_reg(OFF_EVT_STATUS, v); check(v, 32'h0);
        cyc(2); check(irq, 32'h0);
        @(posedge clk) w_gen <= 1'b1;
        @(posedge clk) w_gen <= 1'b0;
        wr_reg(OFF_EVT_ENABLE, 32'h0);
        cyc(3); check(irq, 32'h0);
        rd_reg(OFF_EVT_STATUS, v); check(v, 32'h0000_0800);
        rd_reg(OFF_GENCALL_CLR, v); check(v, 32'h1);
        rd_reg(OFF_EVT_STATUS, v); check(v, 32'h0000_0000);
    endtask : t_events

    // TX queue filled past full, then one word drained in order
    task automatic t_tx;
        for (int i = 0; i < 5; i++) wr_reg(OFF_DATA_CMD, 32'h10 + i);
        rd_reg(OFF_TX_LEVEL, v); check(v, 32'h4);
        rd_reg(OFF_STATUS, v);   check(v[2:1], 32'h0);
        @(posedge clk) w_pop <= 1'b1;
        @(posedge clk) w_pop <= 1'b0;
        cyc(3); check(popped, 32'h010);
        rd_reg(OFF_TX_LEVEL, v); check(v, 32'h3);
        rd_reg(OFF_STATUS, v);   check(v[2:1], 32'h1);
    endtask : t_tx

    // RX queue filled past full, then one byte read
    task automatic t_rx;
        @(posedge clk) w_push <= 1'b1;
        cyc(4);
        @(posedge clk) w_push <= 1'b0;
        cyc(3);
        rd_reg(OFF_RX_LEVEL, v); check(v, 32'h4);
        rd_reg(OFF_STATUS, v);   check(v[4:3], 32'h3);
        rd_reg(OFF_DATA_CMD, v); check(v[7:0], 32'ha0);
        rd_reg(OFF_RX_LEVEL, v); check(v, 32'h3);
        rd_reg(OFF_STATUS, v);   check(v[4:3], 32'h1);
    endtask : t_rx

    // Disable flushes both queues but keeps pending events
    task automatic t_disable;
        @(posedge clk) w_start <= 1'b1;
        @(posedge clk) w_start <= 1'b0;
        t_enable(1'b0);
        check(rx_nack, 32'h1);
        rd_reg(OFF_TX_LEVEL, v);   check(v, 32'h0);
        rd_reg(OFF_RX_LEVEL, v);   check(v, 32'h0);
        rd_reg(OFF_STATUS, v);     check(v[4:1], 32'h3);
        rd_reg(OFF_EVT_STATUS, v); check(v, 32'h0000_0400);
        wr_reg(OFF_DATA_CMD, 32'h55);
        rd_reg(OFF_TX_LEVEL, v);   check(v, 32'h0);
        rd_reg(OFF_START_CLR, v);
    endtask : t_disable

    // Read command while answering a remote read aborts the TX path
    task automatic t_abort;
        t_enable(1'b1);
        wr_reg(OFF_DATA_CMD, 32'h21);
        @(posedge clk) rdq <= 1'b1;
        wr_reg(OFF_DATA_CMD, 32'h122);
        @(posedge clk) rdq <= 1'b0;
        cyc(2);
        rd_reg(OFF_ABORT_CAUSE, v); check(v, 32'h0000_8000);
        rd_reg(OFF_EVT_STATUS, v);  check(v, 32'h0000_0040);
        rd_reg(OFF_TX_LEVEL, v);    check(v, 32'h0);
        wr_reg(OFF_DATA_CMD, 32'h23);
        rd_reg(OFF_TX_LEVEL, v);    check(v, 32'h0);
        rd_reg(OFF_ABORT_CLR, v);
        rd_reg(OFF_ABORT_CAUSE, v); check(v, 32'h0);
        rd_reg(OFF_EVT_STATUS, v);  check(v, 32'h0);
        wr_reg(OFF_DATA_CMD, 32'h24);
        rd_reg(OFF_TX_LEVEL, v);    check(v, 32'h1);
    endtask : t_abort

    // Master and slave activity flags
    task automatic t_busy;
        @(posedge clk) mst <= 1'b1;
        cyc(2);
        rd_reg(OFF_STATUS, v); check(v[6:5], 32'h1);
        check(v[0], 32'h1);
        @(posedge clk) begin
            mst <= 1'b0;
            slv <= 1'b1;
        end
        cyc(2);
        rd_reg(OFF_STATUS, v); check(v[6:5], 32'h2);
        @(posedge clk) slv <= 1'b0;
        cyc(2);
        rd_reg(OFF_STATUS, v); check(v[6:5], 32'h0);
    endtask : t_busy

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_enable(1'b1);
        t_events();
        t_tx();
        t_rx();
        t_disable();
        t_abort();
        t_busy();
        tally_and_finish();
    end
endmodule : icsr_top_test
`default_nettype wire
